// [src/sac_pkg.sv]
// Shared constants for the converter start and serial readout block
package sac_pkg;

    // ****************************************************************
    // Result word
    // ****************************************************************
    localparam int RESULT_BITS = 15;
    localparam int TAG_BITS = 1;
    localparam int WORD_BITS = RESULT_BITS + TAG_BITS;
    localparam int FIFO_DEPTH = 4;
    localparam logic [RESULT_BITS-1:0] RESULT_RESET = 15'h0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLOCK_HZ = 40000000;
    localparam int REINIT_TIME_MS = 10;
    localparam int REINIT_CYCLES = REINIT_TIME_MS * (CLOCK_HZ / 1000);

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_CONVERT,
        SAC_STORE
    } sac_state_e;

endpackage

// [src/sac_fifo.sv]
// Small result FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sac_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_flush,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_check
        $error("sac_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    // Wrap a pointer at DEPTH, which need not be a power of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            bump = '0;
        end else begin
            bump = p + AW'(1);
        end
    endfunction

    // Honest full and empty from the fill count
    assign o_in_ready = (cnt_q != CW'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Next pointers, count and storage
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = i_in_data;
            wr_d = bump(wr_q);
        end
        if (pop) begin
            rd_d = bump(rd_q);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
        if (i_flush) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
    end

    // Register stage
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

endmodule // sac_fifo

`default_nettype wire

// [src/sac_convert_readout.sv]
// Conversion sequencer and serial result readout of the converter
//
// Overview of operation
// R1: Reset on power-up or supply below 2V
// R2: Controller waits 10ms after reset event
// R3: Conversions during reinitialisation give invalid results
// R4: Strobe rising edge starts sampling
// R5: Strobe falling edge starts conversion and readout
// R6: Serial clock edges time the conversion
// R7: Controller drives strobe high about 28.5ns; the controller model holds it high for two i_clock cycles (50ns)
// R8: Serial clock falling edge shifts next bit, MSB first
// R9: Controller supplies 105MHz serial clock for 5Msps; the block takes a serial clock of at most half of i_clock, 20MHz
// R10: First result of a burst is invalid; the code tags it only after reset or a supply drop
// R11: Controller times strobe falling edge low-jitter
// R12: Readout carries previous conversion's 15 bits
// R13: Results are two's complement, receiver sign-extends
// R14: Controller matches selected serial signalling
// R15: Controller assembles word, one valid per readout
`timescale 1ns/1ps
`default_nettype none

module sac_convert_readout #(
    parameter int REINIT_CYCLES_P = sac_pkg::REINIT_CYCLES,
    parameter int RESULT_BITS_P = sac_pkg::RESULT_BITS,
    parameter int FIFO_DEPTH_P = sac_pkg::FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_supply_low,
    input wire logic i_convert_strobe,
    input wire logic i_serial_clock,
    input wire logic [RESULT_BITS_P-1:0] i_sample_code,
    output logic o_serial_data,
    output logic o_sampling,
    output logic o_converting,
    output logic o_ready,
    output logic o_result_invalid,
    output logic o_store_stall
);
    import sac_pkg::*;

    // Strobe and serial clock are plain levels sampled on i_clock. A conversion
    // is a strobe rise, a strobe fall, then fifteen serial clock falls, each of
    // which puts the next bit of the previous result on the data pin.
    // Results are two's complement and pass through the block unchanged.

    localparam int RW = RESULT_BITS_P;
    localparam int WW = RW + TAG_BITS;
    localparam int RCW = $clog2(REINIT_CYCLES_P + 1);
    localparam int BCW = $clog2(RW + 1);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Two result bits at least, so the shift always keeps a lower part
    if (REINIT_CYCLES_P < 1 || RW < 2 || FIFO_DEPTH_P < 2) begin : g_check
        $error("sac_convert_readout parameters out of range");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    // Sequencer state, settle count and pin history
    sac_state_e state_q, state_d;
    logic [RCW-1:0] reinit_q, reinit_d;
    logic strobe_q, strobe_d, sclk_q, sclk_d;
    logic [RW-1:0] shift_q, shift_d;
    logic [RW-1:0] code_q, code_d;
    logic code_ok_q, code_ok_d;
    logic [BCW-1:0] bits_q, bits_d;
    logic sdo_q, sdo_d;
    logic invalid_q, invalid_d;
    logic stall_q, stall_d;
    logic por_event;
    logic strobe_rise, strobe_fall, sclk_fall;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [WW-1:0] fifo_in_data, fifo_out_data;

    // ****************************************************************
    // Edge helpers
    // ****************************************************************
    // Rising edge from the present pin level and its registered copy
    function automatic logic edge_up(input logic level, input logic prev);
        edge_up = level && !prev;
    endfunction

    // Falling edge from the present pin level and its registered copy
    function automatic logic edge_down(input logic level, input logic prev);
        edge_down = !level && prev;
    endfunction

    // ****************************************************************
    // Power-on reset and reinitialisation
    // ****************************************************************
    // The supply flag is a level: while it stands the block is held as after
    // reset, and the settle count only starts once it clears
    // R1: supply drop resets
    assign por_event = i_supply_low;

    // Reload the settle counter on any reset event, then count down
    always_comb begin
        reinit_d = reinit_q;
        if (por_event) begin
            reinit_d = RCW'(REINIT_CYCLES_P);
        end else if (reinit_q != '0) begin
            reinit_d = reinit_q - RCW'(1);
        end
    end

    // Settle counter starts full, so ready stays low through reinitialisation
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            reinit_q <= RCW'(REINIT_CYCLES_P);
        end else begin
            reinit_q <= reinit_d;
        end
    end

    // ****************************************************************
    // Edge detection on the strobe and serial clock pins
    // ****************************************************************
    // Pins are synchronous, so one stage of history finds the edges;
    // limitation: the serial clock must not exceed half of i_clock
    always_comb begin
        strobe_d = i_convert_strobe;
        sclk_d = i_serial_clock;
    end

    // History resets to the idle low level, so no false edge follows reset
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            strobe_q <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            strobe_q <= strobe_d;
            sclk_q <= sclk_d;
        end
    end

    // A missed fall would lose a bit for good, so edges use the live pin
    assign strobe_rise = edge_up(i_convert_strobe, strobe_q);
    assign strobe_fall = edge_down(i_convert_strobe, strobe_q);
    assign sclk_fall = edge_down(i_serial_clock, sclk_q);

    // ****************************************************************
    // Result FIFO between conversion and readout
    // ****************************************************************
    // Word is {valid tag, code}; a full FIFO stalls the store step
    // Each conversion start pops before its own store pushes, so the FIFO
    // holds at most one word in normal use; the stall path is a guard only
    assign fifo_in_valid = (state_q == SAC_STORE);
    assign fifo_in_data = {code_ok_q, code_q};
    assign fifo_out_ready = (state_q == SAC_SAMPLE) && strobe_fall && !por_event;

    sac_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH_P)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_flush(por_event),
        .i_in_valid(fifo_in_valid),
        .i_in_data(fifo_in_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(fifo_out_ready)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Strobe edges during conversion are ignored until the word is stored.
    // Trade-off: a burst counts as new only when no result is held, which is
    // after reset or a supply drop; a long idle keeps the last result valid.
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        code_d = code_q;
        code_ok_d = code_ok_q;
        bits_d = bits_q;
        sdo_d = sdo_q;
        invalid_d = invalid_q;
        stall_d = 1'b0;
        case (state_q)
            SAC_IDLE: begin
                // Rises in any other state are refused until the store ends
                // R4: rise starts sampling
                if (strobe_rise) begin
                    state_d = SAC_SAMPLE;
                end
            end
            SAC_SAMPLE: begin
                // R5: fall starts conversion
                if (strobe_fall) begin
                    state_d = SAC_CONVERT;
                    // The code is taken at the fall, when sampling ends
                    code_d = i_sample_code;
                    // R3: early start tagged
                    code_ok_d = (reinit_q == '0);
                    bits_d = '0;
                    // R12: previous result read
                    if (fifo_out_valid) begin
                        shift_d = fifo_out_data[RW-1:0];
                        invalid_d = !fifo_out_data[RW];
                    end else begin
                        // R10: no previous result
                        shift_d = RESULT_RESET;
                        invalid_d = 1'b1;
                    end
                end
            end
            SAC_CONVERT: begin
                // R6: serial clock paces conversion
                if (sclk_fall) begin
                    // Data moves only on a seen fall, so it stands a whole period
                    // R8: MSB first on fall
                    sdo_d = shift_q[RW-1];
                    shift_d = {shift_q[RW-2:0], 1'b0};
                    bits_d = bits_q + BCW'(1);
                    if (bits_q == BCW'(RW - 1)) begin
                        state_d = SAC_STORE;
                    end
                end
            end
            SAC_STORE: begin
                // A full FIFO holds the word here and raises the stall flag
                // R13: code kept as two's complement
                if (fifo_in_ready) begin
                    state_d = SAC_IDLE;
                end else begin
                    stall_d = 1'b1;
                end
            end
            default: begin
                state_d = SAC_IDLE;
            end
        endcase
        // A half-read word is dropped; the receiver then sees a short frame
        // R1: supply drop aborts
        if (por_event) begin
            state_d = SAC_IDLE;
            shift_d = RESULT_RESET;
            bits_d = '0;
            sdo_d = 1'b0;
            invalid_d = 1'b1;
        end
    end

    // Sequencer register stage only
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state_q <= SAC_IDLE;
            shift_q <= RESULT_RESET;
            code_q <= RESULT_RESET;
            code_ok_q <= 1'b0;
            bits_q <= '0;
            sdo_q <= 1'b0;
            invalid_q <= 1'b1;
            stall_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            code_q <= code_d;
            code_ok_q <= code_ok_d;
            bits_q <= bits_d;
            sdo_q <= sdo_d;
            invalid_q <= invalid_d;
            stall_q <= stall_d;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    logic ready_q, sampling_q, converting_q;
    logic ready_d, sampling_d, converting_d;

    // Status next values follow the next state, so the flags stand with it
    always_comb begin
        ready_d = (reinit_d == '0);
        sampling_d = (state_d == SAC_SAMPLE);
        converting_d = (state_d == SAC_CONVERT);
    end

    // Status flags are flops, so the far side never sees a decode glitch
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            ready_q <= 1'b0;
            sampling_q <= 1'b0;
            converting_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
            sampling_q <= sampling_d;
            converting_q <= converting_d;
        end
    end

    // Ports driven straight from the flops above
    assign o_serial_data = sdo_q;
    assign o_sampling = sampling_q;
    assign o_converting = converting_q;
    assign o_ready = ready_q;
    assign o_result_invalid = invalid_q;
    assign o_store_stall = stall_q;

endmodule // sac_convert_readout

`default_nettype wire

// [verif/sac_convert_readout_checker.sv]
// Concurrent checks on the ports of the converter start and readout block
`timescale 1ns/1ps
`default_nettype none

module sac_convert_readout_checker #(
    parameter int REINIT_CYCLES_P = 20
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_supply_low,
    input wire logic i_convert_strobe,
    input wire logic i_serial_clock,
    input wire logic o_serial_data,
    input wire logic o_sampling,
    input wire logic o_converting,
    input wire logic o_ready,
    input wire logic o_result_invalid,
    input wire logic o_store_stall
);
    int settle_q;
    logic [4:0] falls_q;
    logic stored_q;

    // Settle age saturates so a long run cannot wrap it
    always_ff @(posedge i_clock) begin
        if (!i_rstn || i_supply_low) begin
            settle_q <= 0;
        end else if (settle_q < REINIT_CYCLES_P + 8) begin
            settle_q <= settle_q + 1;
        end
    end

    // Serial clock falls seen in one readout, and whether a result exists
    always_ff @(posedge i_clock) begin
        if (!i_rstn || !o_converting) begin
            falls_q <= 5'h00;
        end else if ($fell(i_serial_clock)) begin
            falls_q <= falls_q + 5'h01;
        end
        if (!i_rstn || i_supply_low) begin
            stored_q <= 1'b0;
        end else if ($fell(o_converting)) begin
            stored_q <= 1'b1;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    sequence s_rise;
        $rose(i_convert_strobe) && !o_sampling && !o_converting;
    endsequence
    sequence s_fall;
        o_sampling && $fell(i_convert_strobe) && !i_supply_low;
    endsequence

    property p_reset_values;
        disable iff (1'b0) !i_rstn |=> !o_sampling && !o_converting && !o_ready
            && o_result_invalid && !o_serial_data && !o_store_stall;
    endproperty
    property p_supply_drop;
        i_supply_low |-> ##[1:2] !o_ready;
    endproperty
    property p_ready_early;
        $rose(o_ready) |-> settle_q >= REINIT_CYCLES_P - 1;
    endproperty
    property p_sample_start;
        s_rise |-> ##[1:2] o_sampling;
    endproperty
    property p_convert_start;
        s_fall |=> o_converting;
    endproperty
    property p_data_hold;
        !$fell(i_serial_clock) && !i_supply_low && !$past(i_supply_low) |=> $stable(o_serial_data);
    endproperty
    property p_fifteen_falls;
        $fell(o_converting) && !i_supply_low && !$past(i_supply_low) |-> falls_q == 5'h0f;
    endproperty
    property p_first_invalid;
        $rose(o_converting) && !stored_q |-> o_result_invalid;
    endproperty
    property p_early_invalid;
        $rose(o_converting) && !o_ready |-> o_result_invalid;
    endproperty

    a_reset_values: assert property (p_reset_values)
        else $error("outputs not at reset values");
    a_supply_drop: assert property (p_supply_drop)
        else $error("ready kept through supply dip");
    a_ready_early: assert property (p_ready_early)
        else $error("ready raised before settle time");
    a_sample_start: assert property (p_sample_start)
        else $error("strobe rise did not start sampling");
    a_convert_start: assert property (p_convert_start)
        else $error("strobe fall did not start conversion");
    a_data_hold: assert property (p_data_hold)
        else $error("serial data moved without a clock fall");
    a_fifteen_falls: assert property (p_fifteen_falls)
        else $error("readout ended without fifteen clock falls");
    a_first_invalid: assert property (p_first_invalid)
        else $error("first readout of a burst not tagged invalid");
    a_early_invalid: assert property (p_early_invalid)
        else $error("readout before ready not tagged invalid");
endmodule // sac_convert_readout_checker

bind sac_convert_readout sac_convert_readout_checker #(.REINIT_CYCLES_P(REINIT_CYCLES_P)) u_chk (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_supply_low(i_supply_low),
    .i_convert_strobe(i_convert_strobe), .i_serial_clock(i_serial_clock),
    .o_serial_data(o_serial_data), .o_sampling(o_sampling), .o_converting(o_converting),
    .o_ready(o_ready), .o_result_invalid(o_result_invalid), .o_store_stall(o_store_stall));
`default_nettype wire

// [verif/sac_ctrl_model.sv]
// Controller model: drives strobe and serial clock, assembles result words
`timescale 1ns/1ps
`default_nettype none

module sac_ctrl_model (
    input wire logic i_clock,
    input wire logic i_go,
    input wire logic [2:0] i_half,
    input wire logic i_serial_data,
    input wire logic i_result_invalid,
    output logic o_convert_strobe,
    output logic o_serial_clock,
    output logic [14:0] o_word,
    output logic o_word_invalid,
    output logic o_done
);
    initial begin
        o_convert_strobe = 1'b0;
        o_serial_clock = 1'b0;
        o_word = 15'h0000;
        o_word_invalid = 1'b0;
        o_done = 1'b0;
    end

    // One frame per request; the serial clock stands low between frames
    always begin
        @(posedge i_clock);
        if (i_go) begin
            @(negedge i_clock);
            o_done = 1'b0;
            o_convert_strobe = 1'b1;
            repeat (2) @(negedge i_clock);
            o_convert_strobe = 1'b0;
            repeat (2) @(negedge i_clock);
            // clock each bit, capture MSB first
            for (int i = 0; i < 15; i++) begin
                o_serial_clock = 1'b1;
                repeat (i_half) @(negedge i_clock);
                o_serial_clock = 1'b0;
                repeat (i_half) @(negedge i_clock);
                o_word = {o_word[13:0], i_serial_data};
                if (i == 0) o_word_invalid = i_result_invalid;
            end
            repeat (4) @(negedge i_clock);
            o_done = 1'b1;
        end
    end
endmodule // sac_ctrl_model
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the converter start and serial readout block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import sac_pkg::*;
    localparam int REINIT = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic supply_low = 1'b0;
    logic go = 1'b0;
    logic [2:0] half = 3'h2;
    logic [RESULT_BITS-1:0] code = 15'h0000;
    logic [RESULT_BITS-1:0] word;
    logic strobe, sclk, sdo, sampling, converting, ready, invalid, stall, word_inv, done;
    int mismatches = 0;
    int total_checks = 0;

    always #12.5 clk = ~clk;

    sac_convert_readout #(.REINIT_CYCLES_P(REINIT)) dut (.i_clock(clk), .i_rstn(rstn),
        .i_supply_low(supply_low), .i_convert_strobe(strobe), .i_serial_clock(sclk),
        .i_sample_code(code), .o_serial_data(sdo), .o_sampling(sampling),
        .o_converting(converting), .o_ready(ready), .o_result_invalid(invalid),
        .o_store_stall(stall));
    sac_ctrl_model partner (.i_clock(clk), .i_go(go), .i_half(half), .i_serial_data(sdo),
        .i_result_invalid(invalid), .o_convert_strobe(strobe), .o_serial_clock(sclk),
        .o_word(word), .o_word_invalid(word_inv), .o_done(done));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_bit(input logic act, input logic exp);
        total_checks++;
        if (act !== exp) begin
            mismatches++;
            $display("unexpected at %0t: bit %b want %b", $time, act, exp);
        end
    endtask

    task automatic check_word(input logic [RESULT_BITS-1:0] act,
        input logic [RESULT_BITS-1:0] exp);
        total_checks++;
        if (act !== exp) begin
            mismatches++;
            $display("unexpected at %0t: word %h want %h", $time, act, exp);
        end
    endtask

    // One frame through the partner; compares the tag, and the word read back only when cmp is set
    task automatic convert(input logic [14:0] c, input logic [14:0] w, input logic cmp,
        input logic inv);
        int n;
        @(negedge clk);
        code = c;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        @(negedge clk);
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            $display("unexpected at %0t: readout never finished", $time);
            stop_test();
        end else begin
            if (cmp) begin
                check_word(word, w);
            end
            check_bit(word_inv, inv);
        end
    endtask

    task automatic t_burst;
        convert(15'h1234, 15'h0000, 1'b0, 1'b1);
        convert(15'h4abc, 15'h1234, 1'b1, 1'b1);
        half = 3'h5;
        convert(15'h0001, 15'h4abc, 1'b1, 1'b0);
        half = 3'h2;
        convert(15'h7fff, 15'h0001, 1'b1, 1'b0);
        $display("burst test done");
    endtask

    task automatic t_supply;
        int n;
        @(negedge clk);
        supply_low = 1'b1;
        repeat (3) @(negedge clk);
        check_bit(ready, 1'b0);
        supply_low = 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check_bit(n >= REINIT - 2 && n <= REINIT + 3, 1'b1);
        convert(15'h2222, 15'h0000, 1'b0, 1'b1);
        convert(15'h5555, 15'h2222, 1'b1, 1'b0);
        $display("supply dip test done");
    endtask

    // Reset held for twenty cycles, outputs judged before release
    task automatic t_reset;
        repeat (20) @(negedge clk);
        check_bit(ready, 1'b0);
        check_bit(invalid, 1'b1);
        check_bit(converting, 1'b0);
        check_bit(sampling, 1'b0);
        check_bit(stall, 1'b0);
        rstn = 1'b1;
        $display("reset test done");
    endtask

    initial begin
        t_reset();
        t_burst();
        t_supply();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
